// ---- flash_regs_defines.vh ----
`ifndef FLASH_REGS_DEFINES_VH
`define FLASH_REGS_DEFINES_VH
// opcodes seen on the serial link
`define CMD_WRITE_ENABLE    8'h06
`define CMD_WRITE_DISABLE   8'h04
`define CMD_READ_STATUS_LO  8'h05
`define CMD_READ_STATUS_HI  8'h35
`define CMD_READ_CONFIG     8'h15
`define CMD_WRITE_STATUS    8'h01
`define CMD_WRITE_STATUS_HI 8'h31
`define CMD_WRITE_CONFIG    8'h11
`define CMD_PAGE_PROGRAM    8'h02
`define CMD_PAGE_ERASE      8'h81
`define CMD_SECTOR_CLEAR    8'h20
`define CMD_BLOCK32_ERASE   8'h52
`define CMD_BLOCK_ERASE     8'hd8
`define CMD_CHIP_ERASE      8'hc7
`define CMD_CHIP_ERASE_ALT  8'h60
`define CMD_SUSPEND         8'h75
`define CMD_RESUME          8'h7a
`define CMD_RESET_ENABLE    8'h66
`define CMD_RESET           8'h99
`define CMD_ENTER_4BYTE     8'hb7
`define CMD_EXIT_4BYTE      8'he9
// array operation kinds handed to the array engine
`define OP_PAGE_PROGRAM     3'h0
`define OP_PAGE_ERASE       3'h1
`define OP_SECTOR_CLEAR     3'h2
`define OP_BLOCK32_ERASE    3'h3
`define OP_BLOCK_ERASE      3'h4
`define OP_CHIP_ERASE       3'h5
// link bit counts at frame end
`define BITS_OPCODE         6'd8
`define BITS_ONE_BYTE       6'd16
`define BITS_TWO_BYTES      6'd24
`define BITS_MAX            6'h3f
// status field positions in a written byte
`define ST_LOCK_LO          7
`define ST_LEVEL            6:2
`define ST_CMP              6
`define ST_SEC_LOCKS        5:3
`define ST_QUAD             1
`define ST_LOCK_HI          0
// configuration field positions
`define CF_HOLD_RESET       7
`define CF_STRENGTH         6:5
`define CF_LEARN            4
`define CF_DUMMY            3
`define CF_SCHEME           2
`define CF_ADDR_POWER_ON    1
// protection and pattern
`define PROTECT_NONE        5'h00
`define LEARN_PATTERN       8'h34
// dummy clock counts, default and alternate
`define DUMMY_2IO_DEF       4'h4
`define DUMMY_2IO_ALT       4'h8
`define DUMMY_4IO_DEF       4'h6
`define DUMMY_4IO_ALT       4'ha
`define DUMMY_DTR2_DEF      4'h6
`define DUMMY_DTR2_ALT      4'h8
`define DUMMY_DTR4_DEF      4'h8
`define DUMMY_DTR4_ALT      4'ha
// timing
`define CLK_PERIOD_NS       20
`define WRITE_TIME_US       5
// self-timed write length in core cycles, 5 us of 20 ns cycles, sized to the counter
`define WRITE_CYCLES_DEF    18'd250
`define WRITE_COUNT_W       18
// pin synchroniser: sclk, cs_n, si, wp_n, hold_reset_n ; reset levels
`define PIN_COUNT           5
`define PIN_RESET_VALUES    5'h1a
`endif

// ---- pin_sync.v ----
`timescale 1ns/100ps
// two-flop synchroniser bank for pins from outside the core clock
module pin_sync #(
	parameter WIDTH = 1,
	parameter [WIDTH-1:0] RESET_VALUES = {WIDTH{1'b0}}
) (
	input  wire             core_clk,
	input  wire             reset,
	input  wire [WIDTH-1:0] pins,
	output wire [WIDTH-1:0] pins_synced
);
	genvar i;
	// one pair of flops per pin, each pair its own driver
	generate
		for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
			reg stage_one; // first flop, read only by stage_two
			reg stage_two; // settled copy
			always @(posedge core_clk) begin
				if (reset) begin
					stage_one <= RESET_VALUES[i];
					stage_two <= RESET_VALUES[i];
				end else begin
					stage_one <= pins[i];
					stage_two <= stage_one;
				end
			end
			assign pins_synced[i] = stage_two;
		end
	endgenerate
endmodule

// ---- flash_status_config_regs.v ----
`timescale 1ns/100ps
`include "flash_regs_defines.vh"
// Notes on behaviour
// - busy flag high during program, erase, write
// - latch clear rejects status write, program, erase
// - protect level selects region refused for alteration
// - protect level writable only outside hardware protection
// - chip erase runs only with no protection
// - lock mode 00 allows writes whenever latch set
// - lock mode 01 locks while protect pin low and quad enable off
// - lock modes 10 and 11 both lock until power cycle
// - quad enable turns control pins into data
// - fail flag set on failure, reset, protected
// - fail flag clears on success, never stops operation
// - security locks set individually, cleared only by reset
// - complement bit joins level for protected area
// - paused flag set by suspend, cleared by resume/reset
// - config read opcode shifts out register anytime
// - shared pin hold or reset, off when quad
// - two strength bits choose read drive strength
// - learning pattern driven in dummy when enabled
// - dummy select picks dummy clock counts
// - scheme select; block locks set at reset
// - power-on address mode chooses start width
// - current address mode shows present width
// - write enable opcode sets the latch
// - config write needs exact byte boundary, clears latch
module flash_status_config_regs #(
	parameter [`WRITE_COUNT_W-1:0] WRITE_CYCLES = `WRITE_CYCLES_DEF
) (
	input  wire       core_clk,
	input  wire       reset,
	input  wire       sclk,
	input  wire       cs_n,
	input  wire       si,
	input  wire       wp_n,
	input  wire       hold_reset_n,
	input  wire       region_protected,
	input  wire       op_done,
	input  wire       op_ok,
	output reg        so_out,
	output reg        so_oe_n,
	output reg        op_request,
	output reg  [2:0] op_kind,
	output reg        op_abort,
	output reg        suspend_req,
	output reg        resume_req,
	output reg        busy_flag,
	output reg        write_enable_latch,
	output reg        wp_function_en,
	output reg        hold_function_en,
	output reg        reset_function_en,
	output reg  [1:0] drive_strength,
	output reg  [7:0] learn_pattern,
	output reg  [3:0] dummy_2io,
	output reg  [3:0] dummy_4io,
	output reg  [3:0] dummy_dtr2,
	output reg  [3:0] dummy_dtr4,
	output reg        block_scheme,
	output reg        block_locks_set,
	output reg        address_4byte
);
	// one-hot activity states
	localparam [2:0] ST_IDLE  = 3'b001;
	localparam [2:0] ST_WRITE = 3'b010;
	localparam [2:0] ST_ARRAY = 3'b100;

	wire [`PIN_COUNT-1:0] pins_s;            // synchronised pins
	wire       sclk_s  = pins_s[0];          // link clock level
	wire       cs_n_s  = pins_s[1];          // chip select level
	wire       si_s    = pins_s[2];          // serial input
	wire       wp_n_s  = pins_s[3];          // protect pin
	wire       hold_s  = pins_s[4];          // hold or reset pin
	reg        sclk_prev;                    // for edge finding
	reg        cs_prev;                      // for frame end finding
	reg  [5:0] bit_count;                    // rising edges this frame
	reg  [23:0] shift_in;                    // received bits
	reg  [7:0] opcode;                       // first byte of frame
	reg  [2:0] state;                        // activity state
	reg  [`WRITE_COUNT_W-1:0] write_count;   // self-timed write cycle
	reg        reset_armed;                  // reset enable seen
	// status fields
	reg  [4:0] array_protect_level;
	reg        status_lock_mode_hi;
	reg        status_lock_mode_lo;
	reg        quad_enable;
	reg        op_fail_flag;
	reg        security_lock_1;
	reg        security_lock_2;
	reg        security_lock_3;
	reg        complement_protect;
	reg        paused_flag;
	// configuration fields
	reg        hold_reset_select;
	reg        output_strength_hi;
	reg        output_strength_lo;
	reg        learning_pattern_enable;
	reg        dummy_cycle_select;
	reg        protect_scheme_select;
	reg        power_on_address_mode;
	reg        current_address_mode;
	reg  [7:0] read_byte;                    // byte being shifted out
	reg        read_cmd;                     // opcode is a register read
	reg        array_cmd;                    // opcode is program or erase
	reg  [2:0] array_kind;                   // kind for that opcode

	wire sclk_rise = sclk_s & ~sclk_prev;
	wire sclk_fall = ~sclk_s & sclk_prev;
	wire frame_end = cs_n_s & ~cs_prev;
	// hardware protection only while the pin keeps its control role
	wire hw_protected = ~status_lock_mode_hi & status_lock_mode_lo & ~wp_n_s & ~quad_enable;
	wire status_locked = status_lock_mode_hi | hw_protected;
	wire status_write_ok = write_enable_latch & ~status_locked;
	wire hard_reset = reset_function_en & ~hold_s;
	wire soft_reset = frame_end & reset_armed & (opcode == `CMD_RESET) & (bit_count == `BITS_OPCODE);
	wire any_reset = soft_reset | hard_reset;
	wire idle = state[0];
	wire [7:0] data_lo = shift_in[7:0];  // last byte of the frame
	wire [7:0] data_hi = shift_in[15:8]; // byte before it

	pin_sync #(
		.WIDTH        (`PIN_COUNT),
		.RESET_VALUES (`PIN_RESET_VALUES)
	) u_pin_sync (
		.core_clk    (core_clk),
		.reset       (reset),
		.pins        ({hold_reset_n, wp_n, si, cs_n, sclk}),
		.pins_synced (pins_s)
	);

	// byte returned by the register read opcodes
	always @* begin
		read_cmd = 1'b1;
		case (opcode)
			`CMD_READ_STATUS_LO: read_byte = {status_lock_mode_lo, array_protect_level,
				write_enable_latch, busy_flag};
			`CMD_READ_STATUS_HI: read_byte = {paused_flag, complement_protect, security_lock_3,
				security_lock_2, security_lock_1, op_fail_flag, quad_enable, status_lock_mode_hi};
			`CMD_READ_CONFIG: read_byte = {hold_reset_select, output_strength_hi, output_strength_lo,
				learning_pattern_enable, dummy_cycle_select, protect_scheme_select,
				power_on_address_mode, current_address_mode};
			default: begin
				read_byte = 8'h00;
				read_cmd = 1'b0;
			end
		endcase
	end

	// program and erase opcode decode
	always @* begin
		array_cmd = 1'b1;
		case (opcode)
			`CMD_PAGE_PROGRAM:   array_kind = `OP_PAGE_PROGRAM;
			`CMD_PAGE_ERASE:     array_kind = `OP_PAGE_ERASE;
			`CMD_SECTOR_CLEAR:   array_kind = `OP_SECTOR_CLEAR;
			`CMD_BLOCK32_ERASE:  array_kind = `OP_BLOCK32_ERASE;
			`CMD_BLOCK_ERASE:    array_kind = `OP_BLOCK_ERASE;
			`CMD_CHIP_ERASE:     array_kind = `OP_CHIP_ERASE;
			`CMD_CHIP_ERASE_ALT: array_kind = `OP_CHIP_ERASE;
			default: begin
				array_kind = `OP_PAGE_PROGRAM;
				array_cmd = 1'b0;
			end
		endcase
	end

	// link receive side: edges, bit count, shift register
	always @(posedge core_clk) begin
		if (reset) begin
			sclk_prev <= 1'b0;
			cs_prev <= 1'b1;
			bit_count <= 6'h00;
			shift_in <= 24'h000000;
			opcode <= 8'h00;
		end else begin
			sclk_prev <= sclk_s;
			cs_prev <= cs_n_s;
			if (cs_n_s) begin
				// frame closed, count restarts
				bit_count <= 6'h00;
			end else if (sclk_rise) begin
				shift_in <= {shift_in[22:0], si_s};
				if (bit_count != `BITS_MAX)
					bit_count <= bit_count + 6'h01;
				if (bit_count == `BITS_OPCODE - 6'h01)
					opcode <= {shift_in[6:0], si_s};
			end
		end
	end

	// link transmit side: msb first on falling edges
	always @(posedge core_clk) begin
		if (reset) begin
			so_out <= 1'b0;
			so_oe_n <= 1'b1;
		end else if (cs_n_s) begin
			so_oe_n <= 1'b1;
		end else if (sclk_fall && bit_count >= `BITS_OPCODE && read_cmd) begin
			so_out <= read_byte[~bit_count[2:0]];
			so_oe_n <= 1'b0;
		end
	end

	// command execution, activity state and register fields
	always @(posedge core_clk) begin
		if (reset) begin
			state <= ST_IDLE;
			busy_flag <= 1'b0;
			write_count <= {`WRITE_COUNT_W{1'b0}};
			reset_armed <= 1'b0;
			write_enable_latch <= 1'b0;
			array_protect_level <= `PROTECT_NONE;
			status_lock_mode_hi <= 1'b0;
			status_lock_mode_lo <= 1'b0;
			quad_enable <= 1'b0;
			op_fail_flag <= 1'b0;
			security_lock_1 <= 1'b0;
			security_lock_2 <= 1'b0;
			security_lock_3 <= 1'b0;
			complement_protect <= 1'b0;
			paused_flag <= 1'b0;
			hold_reset_select <= 1'b0;
			output_strength_hi <= 1'b0;
			output_strength_lo <= 1'b0;
			learning_pattern_enable <= 1'b0;
			dummy_cycle_select <= 1'b0;
			protect_scheme_select <= 1'b0;
			power_on_address_mode <= 1'b0;
			current_address_mode <= 1'b0;
			op_request <= 1'b0;
			op_kind <= `OP_PAGE_PROGRAM;
			op_abort <= 1'b0;
			suspend_req <= 1'b0;
			resume_req <= 1'b0;
			block_locks_set <= 1'b1;
		end else begin
			// single-cycle strobes default low
			op_request <= 1'b0;
			op_abort <= 1'b0;
			suspend_req <= 1'b0;
			resume_req <= 1'b0;
			block_locks_set <= 1'b0;
			if (frame_end)
				reset_armed <= (opcode == `CMD_RESET_ENABLE) && (bit_count == `BITS_OPCODE);
			// activity progress
			case (state)
				ST_IDLE: busy_flag <= 1'b0;
				ST_WRITE: begin
					if (write_count == {`WRITE_COUNT_W{1'b0}}) begin
						state <= ST_IDLE;
						busy_flag <= 1'b0;
						write_enable_latch <= 1'b0;
					end else begin
						write_count <= write_count - {{(`WRITE_COUNT_W-1){1'b0}}, 1'b1};
					end
				end
				ST_ARRAY: begin
					if (op_done && !paused_flag) begin
						state <= ST_IDLE;
						busy_flag <= 1'b0;
						write_enable_latch <= 1'b0;
						op_fail_flag <= ~op_ok;
					end
				end
				default: begin
					state <= ST_IDLE;
					busy_flag <= 1'b0;
				end
			endcase
			if (any_reset) begin
				// soft or hard reset: volatile state returns to default
				if (state == ST_ARRAY) begin
					op_fail_flag <= 1'b1;
					op_abort <= 1'b1;
				end
				state <= ST_IDLE;
				busy_flag <= 1'b0;
				write_enable_latch <= 1'b0;
				paused_flag <= 1'b0;
				learning_pattern_enable <= 1'b0;
				dummy_cycle_select <= 1'b0;
				current_address_mode <= power_on_address_mode;
				block_locks_set <= 1'b1;
			end else if (frame_end) begin
				case (opcode)
					`CMD_WRITE_ENABLE: if (idle && bit_count == `BITS_OPCODE)
						write_enable_latch <= 1'b1;
					`CMD_WRITE_DISABLE: if (idle && bit_count == `BITS_OPCODE)
						write_enable_latch <= 1'b0;
					`CMD_WRITE_STATUS: if (idle && status_write_ok) begin
						if (bit_count == `BITS_ONE_BYTE || bit_count == `BITS_TWO_BYTES) begin
							status_lock_mode_lo <= data_lo[`ST_LOCK_LO];
							array_protect_level <= data_lo[`ST_LEVEL];
							state <= ST_WRITE;
							busy_flag <= 1'b1;
							write_count <= WRITE_CYCLES;
						end
						if (bit_count == `BITS_TWO_BYTES) begin
							// first byte low half, second byte high half
							status_lock_mode_lo <= data_hi[`ST_LOCK_LO];
							array_protect_level <= data_hi[`ST_LEVEL];
							complement_protect <= data_lo[`ST_CMP];
							{security_lock_3, security_lock_2, security_lock_1} <=
								{security_lock_3, security_lock_2, security_lock_1} |
								data_lo[`ST_SEC_LOCKS];
							quad_enable <= data_lo[`ST_QUAD];
							status_lock_mode_hi <= data_lo[`ST_LOCK_HI];
						end
					end
					`CMD_WRITE_STATUS_HI: if (idle && status_write_ok && bit_count == `BITS_ONE_BYTE) begin
						complement_protect <= data_lo[`ST_CMP];
						{security_lock_3, security_lock_2, security_lock_1} <=
							{security_lock_3, security_lock_2, security_lock_1} |
							data_lo[`ST_SEC_LOCKS];
						quad_enable <= data_lo[`ST_QUAD];
						status_lock_mode_hi <= data_lo[`ST_LOCK_HI];
						state <= ST_WRITE;
						busy_flag <= 1'b1;
						write_count <= WRITE_CYCLES;
					end
					`CMD_WRITE_CONFIG: if (idle && write_enable_latch && bit_count == `BITS_ONE_BYTE) begin
						hold_reset_select <= data_lo[`CF_HOLD_RESET];
						{output_strength_hi, output_strength_lo} <= data_lo[`CF_STRENGTH];
						learning_pattern_enable <= data_lo[`CF_LEARN];
						dummy_cycle_select <= data_lo[`CF_DUMMY];
						protect_scheme_select <= data_lo[`CF_SCHEME];
						power_on_address_mode <= data_lo[`CF_ADDR_POWER_ON];
						state <= ST_WRITE;
						busy_flag <= 1'b1;
						write_count <= WRITE_CYCLES;
					end
					`CMD_SUSPEND: if (state == ST_ARRAY && !paused_flag && bit_count == `BITS_OPCODE) begin
						paused_flag <= 1'b1;
						suspend_req <= 1'b1;
					end
					`CMD_RESUME: if (paused_flag && bit_count == `BITS_OPCODE) begin
						paused_flag <= 1'b0;
						resume_req <= 1'b1;
					end
					`CMD_ENTER_4BYTE: if (bit_count == `BITS_OPCODE)
						current_address_mode <= 1'b1;
					`CMD_EXIT_4BYTE: if (bit_count == `BITS_OPCODE)
						current_address_mode <= 1'b0;
					default: begin
						if (array_cmd && idle && write_enable_latch && bit_count >= `BITS_OPCODE) begin
							if (array_kind == `OP_CHIP_ERASE) begin
								if (array_protect_level == `PROTECT_NONE) begin
									op_request <= 1'b1;
									op_kind <= array_kind;
									state <= ST_ARRAY;
									busy_flag <= 1'b1;
								end
							end else if (region_protected) begin
								op_fail_flag <= 1'b1;
							end else begin
								op_request <= 1'b1;
								op_kind <= array_kind;
								state <= ST_ARRAY;
								busy_flag <= 1'b1;
							end
						end
					end
				endcase
			end
		end
	end

	// pin roles and read-path settings presented as flops
	always @(posedge core_clk) begin
		if (reset) begin
			wp_function_en <= 1'b1;
			hold_function_en <= 1'b1;
			reset_function_en <= 1'b0;
			drive_strength <= 2'h0;
			learn_pattern <= 8'h00;
			dummy_2io <= `DUMMY_2IO_DEF;
			dummy_4io <= `DUMMY_4IO_DEF;
			dummy_dtr2 <= `DUMMY_DTR2_DEF;
			dummy_dtr4 <= `DUMMY_DTR4_DEF;
			block_scheme <= 1'b0;
			address_4byte <= 1'b0;
		end else begin
			wp_function_en <= ~quad_enable;
			hold_function_en <= ~quad_enable & ~hold_reset_select;
			reset_function_en <= ~quad_enable & hold_reset_select;
			drive_strength <= {output_strength_hi, output_strength_lo};
			learn_pattern <= learning_pattern_enable ? `LEARN_PATTERN : 8'h00;
			dummy_2io <= dummy_cycle_select ? `DUMMY_2IO_ALT : `DUMMY_2IO_DEF;
			dummy_4io <= dummy_cycle_select ? `DUMMY_4IO_ALT : `DUMMY_4IO_DEF;
			dummy_dtr2 <= dummy_cycle_select ? `DUMMY_DTR2_ALT : `DUMMY_DTR2_DEF;
			dummy_dtr4 <= dummy_cycle_select ? `DUMMY_DTR4_ALT : `DUMMY_DTR4_DEF;
			block_scheme <= protect_scheme_select;
			address_4byte <= current_address_mode;
		end
	end
endmodule

// ---- flash_regs_checker.sv ----
`timescale 1ns/100ps
// watches the register bank outputs against their causes
module flash_regs_checker (
	input wire       core_clk,
	input wire       reset,
	input wire       cs_n,
	input wire       so_oe_n,
	input wire       op_request,
	input wire       suspend_req,
	input wire       busy_flag,
	input wire       write_enable_latch,
	input wire       wp_function_en,
	input wire       hold_function_en,
	input wire       reset_function_en,
	input wire [7:0] learn_pattern,
	input wire [3:0] dummy_2io,
	input wire [3:0] dummy_4io,
	input wire [3:0] dummy_dtr2,
	input wire [3:0] dummy_dtr4,
	input wire       block_locks_set
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);
	// select idle long enough to pass the sync flops
	sequence cs_idle;
		cs_n [*6];
	endsequence
	// a self-timed cycle that has just ended
	sequence busy_end;
		busy_flag ##1 !busy_flag;
	endsequence
	a_dummy_pairs: assert property (
		(dummy_2io == 4'h4) ? (dummy_4io == 4'h6 && dummy_dtr2 == 4'h6 && dummy_dtr4 == 4'h8)
		: (dummy_2io == 4'h8 && dummy_4io == 4'ha && dummy_dtr2 == 4'h8 && dummy_dtr4 == 4'ha))
		else $error("dummy counts disagree");
	a_pattern_value: assert property (
		learn_pattern == 8'h00 || learn_pattern == 8'h34) else $error("bad learning pattern");
	a_quad_pins: assert property (
		!wp_function_en |-> !hold_function_en && !reset_function_en) else $error("pin role while quad");
	a_pin_role: assert property (
		!(hold_function_en && reset_function_en)) else $error("hold and reset both on");
	a_busy_needs_wel: assert property (
		$rose(busy_flag) |-> $past(write_enable_latch)) else $error("busy without latch");
	a_request_wel: assert property (
		op_request |-> write_enable_latch) else $error("array op without latch");
	a_request_busy: assert property (
		op_request |-> ##[0:1] busy_flag) else $error("array op not busy");
	a_end_clears_wel: assert property (
		busy_end |-> ##[0:1] !write_enable_latch) else $error("latch kept after cycle");
	a_suspend_busy: assert property (
		suspend_req |-> $past(busy_flag)) else $error("suspend while idle");
	a_oe_idle: assert property (
		cs_idle |-> so_oe_n) else $error("output driven while deselected");
	a_locks_reset: assert property (
		disable iff (1'b0) reset |=> block_locks_set) else $error("block locks not set");
endmodule

bind flash_status_config_regs flash_regs_checker chk (.core_clk, .reset, .cs_n, .so_oe_n, .op_request,
	.suspend_req, .busy_flag, .write_enable_latch, .wp_function_en, .hold_function_en, .reset_function_en,
	.learn_pattern, .dummy_2io, .dummy_4io, .dummy_dtr2, .dummy_dtr4, .block_locks_set);

// ---- flash_host_model.sv ----
`timescale 1ns/100ps
// mode 0 link host, 4 core cycles per half bit
module flash_host_model (
	input  wire core_clk,
	input  wire so_out,
	input  wire so_oe_n,
	output reg  sclk,
	output reg  cs_n,
	output reg  si
);
	reg [7:0] rd; // last byte seen on the output line
	initial begin
		sclk = 1'b0;
		cs_n = 1'b1;
		si   = 1'b0;
		rd   = 8'h00;
	end
	// one frame of n bits, msb of v first
	task xfer(input [31:0] v, input integer n);
		integer i;
		begin
			@(posedge core_clk);
			cs_n <= 1'b0;
			si   <= v[31];
			for (i = 0; i < n; i = i + 1) begin
				repeat (4) @(posedge core_clk);
				sclk <= 1'b1;
				// undriven output reads inverted, so a late enable shows up
				rd   <= {rd[6:0], so_oe_n ? ~so_out : so_out};
				repeat (4) @(posedge core_clk);
				sclk <= 1'b0;
				v = v << 1;
				si <= v[31];
			end
			repeat (4) @(posedge core_clk);
			cs_n <= 1'b1;
			si   <= ~si; // released line does not hold its value
			repeat (8) @(posedge core_clk);
		end
	endtask
endmodule

// ---- flash_status_config_regs_tb.sv ----
`timescale 1ns/100ps
module flash_status_config_regs_tb;
	reg core_clk, reset, wp_n, region_protected, op_done, op_ok, hold_n;
	wire sclk, cs_n, si, so_out, so_oe_n, op_request, op_abort, suspend_req, resume_req, busy_flag;
	wire write_enable_latch, wp_function_en, hold_function_en, reset_function_en, block_scheme;
	wire block_locks_set, address_4byte;
	wire [2:0] op_kind;
	wire [1:0] drive_strength;
	wire [7:0] learn_pattern;
	wire [3:0] dummy_2io, dummy_4io, dummy_dtr2, dummy_dtr4;
	integer n_fail = 0, n_tests = 0, n_req = 0, n_abort = 0, n0, i, cyc = 0;
	reg [7:0] d, v;
	flash_status_config_regs #(.WRITE_CYCLES(18'd10)) uut (.core_clk(core_clk), .reset(reset), .sclk(sclk),
		.cs_n(cs_n), .si(si), .wp_n(wp_n), .hold_reset_n(hold_n), .region_protected(region_protected),
		.op_done(op_done), .op_ok(op_ok), .so_out(so_out), .so_oe_n(so_oe_n), .op_request(op_request),
		.op_kind(op_kind), .op_abort(op_abort), .suspend_req(suspend_req), .resume_req(), .busy_flag(busy_flag),
		.write_enable_latch(write_enable_latch), .wp_function_en(wp_function_en),
		.hold_function_en(hold_function_en), .reset_function_en(reset_function_en),
		.drive_strength(drive_strength), .learn_pattern(learn_pattern), .dummy_2io(dummy_2io),
		.dummy_4io(dummy_4io), .dummy_dtr2(dummy_dtr2), .dummy_dtr4(dummy_dtr4), .block_scheme(block_scheme),
		.block_locks_set(block_locks_set), .address_4byte(address_4byte));
	flash_host_model host (.core_clk(core_clk), .so_out(so_out), .so_oe_n(so_oe_n), .sclk(sclk), .cs_n(cs_n),
		.si(si));
	initial begin
		core_clk = 1'b0;
		forever #10 core_clk = ~core_clk;
	end
	// count array requests; cut a hang short
	always @(posedge core_clk) begin
		if (op_request === 1'b1) n_req = n_req + 1;
		if (op_abort === 1'b1) n_abort = n_abort + 1;
		cyc = cyc + 1;
		if (cyc == 40000) begin
			n_fail = n_fail + 1;
			wrap_up;
		end
	end
	task chk(input string nm, input [15:0] e, input [15:0] g);
		begin
			n_tests = n_tests + 1;
			if (g !== e) begin
				n_fail = n_fail + 1;
				$display("ERROR %s expected %h seen %h", nm, e, g);
			end
		end
	endtask
	// read one register byte
	task rd(input [7:0] op, output [7:0] r);
		begin
			host.xfer({op, 24'h0}, 16);
			r = host.rd;
		end
	endtask
	// write enable, then the frame
	task wr(input [31:0] f, input integer n);
		begin
			host.xfer(32'h06000000, 8);
			host.xfer(f, n);
		end
	endtask
	// wait out a self-timed cycle
	task idle;
		integer k;
		begin
			for (k = 0; k < 200 && busy_flag !== 1'b0; k = k + 1) @(posedge core_clk);
			@(posedge core_clk);
		end
	endtask
	task done(input ok);
		begin
			@(posedge core_clk);
			op_done <= 1'b1;
			op_ok   <= ok;
			@(posedge core_clk);
			op_done <= 1'b0;
		end
	endtask
	task wrap_up;
		begin
			$display("comparisons %0d mismatches %0d", n_tests, n_fail);
			if (n_fail == 0 && n_tests > 0) begin
				$display("All checks passed");
			end else begin
				$display("Checks failed");
			end
			$finish;
		end
	endtask
	initial begin
		reset = 1'b1;
		wp_n = 1'b1;
		hold_n = 1'b1;
		region_protected = 1'b0;
		op_done = 1'b0;
		op_ok = 1'b0;
		repeat (10) @(posedge core_clk);
		reset <= 1'b0;
		repeat (3) @(posedge core_clk);
		chk("busy", 0, busy_flag);
		chk("dummy_2io", 4'h4, dummy_2io);
		chk("hold_fn", 1, hold_function_en);
		chk("addr_mode", 0, address_4byte);
		rd(8'h15, d);
		chk("config", 8'h00, d);
		$display("reset test done");
		host.xfer(32'h11ff0000, 16);
		idle;
		rd(8'h15, d);
		chk("config_no_wel", 8'h00, d);
		$display("latch test done");
		for (i = 0; i < 4; i = i + 1) begin
			v = {1'b0, i[1:0], i[0], i[1], i[0], i[1], 1'b0};
			wr({8'h11, v, 16'h0}, 16);
			idle;
			chk("wel", 0, write_enable_latch);
			chk("strength", i[1:0], drive_strength);
			chk("pattern", i[0] ? 8'h34 : 8'h00, learn_pattern);
			chk("dummy_4io", i[1] ? 4'ha : 4'h6, dummy_4io);
			chk("scheme", i[0], block_scheme);
			rd(8'h15, d);
			chk("config", v, d);
		end
		$display("config test done");
		wr(32'h11800000, 12);
		idle;
		rd(8'h15, d);
		chk("config_bad_count", 8'h7e, d);
		host.xfer(32'h04000000, 8);
		$display("count test done");
		wp_n <= 1'b0;
		wr(32'h017c4a00, 24);
		idle;
		wp_n <= 1'b1;
		rd(8'h05, d);
		chk("status_lo", 8'h7c, d);
		rd(8'h35, d);
		chk("status_hi", 8'h4a, d);
		chk("wp_fn", 0, wp_function_en);
		chk("hold_fn", 0, hold_function_en);
		n0 = n_req;
		wr(32'hc7000000, 8);
		chk("chip_erase", n0, n_req);
		wr(32'h01000000, 24);
		idle;
		rd(8'h35, d);
		chk("locks_kept", 8'h08, d);
		$display("status test done");
		wr(32'h02000100, 32);
		chk("requests", n0 + 1, n_req);
		chk("kind", 3'h0, op_kind);
		chk("busy", 1, busy_flag);
		done(1'b0);
		rd(8'h35, d);
		chk("fail_set", 8'h0c, d);
		wr(32'h20000000, 32);
		done(1'b1);
		rd(8'h35, d);
		chk("fail_clear", 8'h08, d);
		region_protected <= 1'b1;
		wr(32'h81000000, 32);
		region_protected <= 1'b0;
		chk("protected", n0 + 2, n_req);
		rd(8'h35, d);
		chk("fail_prot", 8'h0c, d);
		$display("array test done");
		wr(32'h02000000, 32);
		host.xfer(32'h75000000, 8);
		rd(8'h35, d);
		chk("paused", 8'h8c, d);
		host.xfer(32'h7a000000, 8);
		rd(8'h35, d);
		chk("resumed", 8'h0c, d);
		done(1'b1);
		$display("suspend test done");
		host.xfer(32'hb7000000, 8);
		chk("addr_4b", 1, address_4byte);
		host.xfer(32'he9000000, 8);
		chk("addr_3b", 0, address_4byte);
		host.xfer(32'h66000000, 8);
		host.xfer(32'h99000000, 8);
		chk("soft_addr", 1, address_4byte);
		rd(8'h15, d);
		chk("soft_config", 8'h67, d);
		wr(32'h11fe0000, 16);
		idle;
		chk("reset_fn", 1, reset_function_en);
		chk("hold_fn_rst", 0, hold_function_en);
		wr(32'h02000000, 32);
		host.xfer(32'h75000000, 8);
		hold_n <= 1'b0;
		repeat (8) @(posedge core_clk);
		hold_n <= 1'b1;
		repeat (8) @(posedge core_clk);
		chk("abort", 1, n_abort);
		chk("busy_abort", 0, busy_flag);
		rd(8'h35, d);
		chk("hard_reset", 8'h0c, d);
		$display("reset pin test done");
		wr(32'h01800000, 16);
		idle;
		wp_n <= 1'b0;
		wr(32'h01040000, 16);
		idle;
		rd(8'h05, d);
		chk("hw_locked", 8'h82, d);
		wp_n <= 1'b1;
		host.xfer(32'h01000000, 16);
		idle;
		rd(8'h05, d);
		chk("hw_unlocked", 8'h00, d);
		wr(32'h31010000, 16);
		idle;
		wr(32'h01040000, 16);
		idle;
		rd(8'h05, d);
		chk("lockdown", 8'h02, d);
		reset <= 1'b1;
		repeat (3) @(posedge core_clk);
		reset <= 1'b0;
		repeat (3) @(posedge core_clk);
		rd(8'h35, d);
		chk("power_cycle", 8'h00, d);
		$display("lock test done");
		wrap_up;
	end
endmodule
